/* logic/ufc_defs.svh */
/*
 Register indices, field positions, reset values and status bits of the flow control block.
 Assumes byte address = 4 * index on a 32-bit APB.
*/
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH
`define UFC_IDX_EFC 6'h0A
`define UFC_IDX_RES1 6'h0B
`define UFC_IDX_RES2 6'h0C
`define UFC_IDX_PAU1 6'h0D
`define UFC_IDX_PAU2 6'h0E
`define UFC_IDX_FCLO 6'h12
`define UFC_IDX_FCHI 6'h13
`define UFC_IDX_STAT 6'h18
`define UFC_IDX_MASK 6'h19
`define UFC_IDX_FLOW 6'h1A
`define UFC_EFC_ENH 4
`define UFC_EFC_SPC 5
`define UFC_EFC_ARTS 6
`define UFC_EFC_ACTS 7
`define UFC_EFC_RST 8'h00
`define UFC_BYTE_RST 8'h00
`define UFC_ST_RST 3'h0
`define UFC_ST_SPC 0
`define UFC_ST_PAUSE 1
`define UFC_ST_RESUME 2
`endif

/* logic/ufc_pkg.sv */
/*
 Types of the flow control block.
 Assumes ufc_defs.svh supplies the numeric constants.
*/
package ufc_pkg;
   typedef enum logic [2:0] {
      UFC_IDLE = 3'b001,
      UFC_LOAD = 3'b010,
      UFC_BUSY = 3'b100
   } ufc_tx_state_e;
   typedef logic [7:0] ufc_char_t;
endpackage

/* logic/ufc_flow_ctl.sv */
/*
 Enhanced flow control of one UART channel with its APB register slave.
 Assumes receiver, fifo level, upstream data and shifter all run on clock; cts_n is an async pin.
*/
// The APB slave port was left to the implementer.
module ufc_flow_ctl (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ufc_pkg::ufc_char_t rx_char,
   input wire logic rx_char_valid,
   input wire logic [7:0] receive_fifo_level,
   input wire ufc_pkg::ufc_char_t tx_data,
   input wire logic tx_data_valid,
   output logic tx_data_take,
   input wire logic shifter_idle,
   output logic tx_load,
   output ufc_pkg::ufc_char_t tx_load_data,
   input wire logic rts_request,
   output logic rts_n,
   input wire logic cts_n,
   output logic irq
);
   import ufc_pkg::*;
`include "ufc_defs.svh"

   logic [7:0] enhanced_function_control;
   ufc_char_t resume_char_one, resume_char_two, pause_char_one, pause_char_two;
   logic [7:0] fc_low, fc_high;
   logic [2:0] int_status, int_mask;
   logic cts_meta, cts_sync;
   logic tx_paused, sent_pause, pend_valid, pend_pause, rts_hold;
   ufc_tx_state_e state;

   // true when c matches the set that mode m selects
   function automatic logic fc_sel(input logic [1:0] m, input ufc_char_t c, input ufc_char_t one,
                                   input ufc_char_t two, input logic both);
      return (m == 2'b01 && c == two) || (m == 2'b10 && c == one) ||
             (m == 2'b11 && both && (c == one || c == two));
   endfunction

   // apb decode
   wire [5:0] idx = paddr[7:2];
   wire idx_ok = idx == `UFC_IDX_EFC || idx == `UFC_IDX_RES1 || idx == `UFC_IDX_RES2 ||
                 idx == `UFC_IDX_PAU1 || idx == `UFC_IDX_PAU2 || idx == `UFC_IDX_FCLO ||
                 idx == `UFC_IDX_FCHI || idx == `UFC_IDX_STAT || idx == `UFC_IDX_MASK ||
                 idx == `UFC_IDX_FLOW;
   wire addr_ok = idx_ok && paddr[1:0] == 2'b00;
   wire next_pready = psel && penable && !pready;
   wire wr = psel && penable && pready && pwrite && addr_ok;
   wire [7:0] wbyte = pwdata[7:0];
   wire [7:0] flow_view = {3'h0, pend_valid, cts_sync, rts_hold, sent_pause, tx_paused};
   wire [7:0] rd_byte =
      idx == `UFC_IDX_EFC  ? enhanced_function_control :
      idx == `UFC_IDX_RES1 ? resume_char_one :
      idx == `UFC_IDX_RES2 ? resume_char_two :
      idx == `UFC_IDX_PAU1 ? pause_char_one :
      idx == `UFC_IDX_PAU2 ? pause_char_two :
      idx == `UFC_IDX_FCLO ? fc_low :
      idx == `UFC_IDX_FCHI ? fc_high :
      idx == `UFC_IDX_STAT ? {5'h00, int_status} :
      idx == `UFC_IDX_MASK ? {5'h00, int_mask} :
      idx == `UFC_IDX_FLOW ? flow_view : 8'h00;
   wire [7:0] next_rdata = addr_ok ? rd_byte : 8'h00;

   // mode decode; everything in-band is off outside enhanced mode
   // enhanced gating
   wire enh = enhanced_function_control[`UFC_EFC_ENH];
   wire [1:0] rx_mode = enh ? enhanced_function_control[1:0] : 2'b00;
   wire [1:0] tx_mode = enh ? enhanced_function_control[3:2] : 2'b00;
   wire tx_fc_on = tx_mode == 2'b01 || tx_mode == 2'b10;
   wire both_ok = enhanced_function_control[3:2] == 2'b01 || enhanced_function_control[3:2] == 2'b10;

   wire pause_hit = rx_char_valid && fc_sel(rx_mode, rx_char, pause_char_one, pause_char_two, both_ok);
   wire resume_hit = rx_char_valid && fc_sel(rx_mode, rx_char, resume_char_one, resume_char_two, both_ok);
   // pause wins if one character matches both
   wire next_tx_paused = rx_mode == 2'b00 ? 1'b0 : pause_hit ? 1'b1 : resume_hit ? 1'b0 : tx_paused;

   wire spc_hit = rx_char_valid && enh && enhanced_function_control[`UFC_EFC_SPC] &&
                  (rx_char == pause_char_one || rx_char == pause_char_two);

   // fifo level against the programmed thresholds
   wire level_over = receive_fifo_level > fc_high;
   wire level_under = receive_fifo_level < fc_low;
   wire need_pause = tx_fc_on && level_over && !sent_pause;
   wire need_resume = tx_fc_on && level_under && sent_pause;
   wire next_sent_pause = !tx_fc_on ? 1'b0 : need_pause ? 1'b1 : need_resume ? 1'b0 : sent_pause;

   wire cts_block = enh && enhanced_function_control[`UFC_EFC_ACTS] && cts_sync;
   wire at_boundary = state == UFC_IDLE && shifter_idle;
   wire pend_go = at_boundary && pend_valid;
   wire data_go = at_boundary && !pend_valid && tx_data_valid && !tx_paused && !cts_block;
   wire next_pend_valid = (need_pause || need_resume) ? 1'b1 :
                          (pend_go || !tx_fc_on) ? 1'b0 : pend_valid;
   wire next_pend_pause = need_pause ? 1'b1 : need_resume ? 1'b0 : pend_pause;
   wire ufc_char_t fc_char = pend_pause ? (tx_mode == 2'b01 ? pause_char_two : pause_char_one)
                                        : (tx_mode == 2'b01 ? resume_char_two : resume_char_one);

   wire auto_rts = enh && enhanced_function_control[`UFC_EFC_ARTS];
   wire next_rts_hold = !auto_rts ? 1'b0 : receive_fifo_level >= fc_high ? 1'b1 :
                        level_under ? 1'b0 : rts_hold;

   // set beats the write-one clear
   wire [2:0] st_set = {resume_hit && tx_paused, pause_hit, spc_hit};
   wire [2:0] st_clr = (wr && idx == `UFC_IDX_STAT) ? pwdata[2:0] : 3'h0;
   wire [2:0] next_int_status = (int_status & ~st_clr) | st_set;

   ufc_tx_state_e next_state;
   always_comb begin
      next_state = state;
      case (state)
         UFC_IDLE: if (pend_go || data_go) next_state = UFC_LOAD;
         UFC_LOAD: next_state = UFC_BUSY;
         UFC_BUSY: if (shifter_idle) next_state = UFC_IDLE;
         default: next_state = UFC_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         enhanced_function_control <= `UFC_EFC_RST;
         resume_char_one <= `UFC_BYTE_RST;
         resume_char_two <= `UFC_BYTE_RST;
         pause_char_one <= `UFC_BYTE_RST;
         pause_char_two <= `UFC_BYTE_RST;
         fc_low <= `UFC_BYTE_RST;
         fc_high <= `UFC_BYTE_RST;
         int_mask <= `UFC_ST_RST;
      end else if (wr) begin
         if (idx == `UFC_IDX_EFC) enhanced_function_control <= wbyte;
         if (idx == `UFC_IDX_RES1) resume_char_one <= wbyte;
         if (idx == `UFC_IDX_RES2) resume_char_two <= wbyte;
         if (idx == `UFC_IDX_PAU1) pause_char_one <= wbyte;
         if (idx == `UFC_IDX_PAU2) pause_char_two <= wbyte;
         if (idx == `UFC_IDX_FCLO) fc_low <= wbyte;
         if (idx == `UFC_IDX_FCHI) fc_high <= wbyte;
         if (idx == `UFC_IDX_MASK) int_mask <= pwdata[2:0];
      end
   end

   // apb answers one cycle into the access phase
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= next_pready;
         pslverr <= next_pready && !addr_ok;
         prdata <= next_pready ? {24'h00_0000, next_rdata} : 32'h0000_0000;
      end
   end

   // cts pin crosses into clock first
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cts_meta <= 1'b1;
         cts_sync <= 1'b1;
      end else begin
         cts_meta <= cts_n;
         cts_sync <= cts_meta;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_paused <= 1'b0;
         sent_pause <= 1'b0;
         pend_valid <= 1'b0;
         pend_pause <= 1'b0;
         rts_hold <= 1'b0;
         int_status <= `UFC_ST_RST;
         state <= UFC_IDLE;
      end else begin
         tx_paused <= next_tx_paused;
         sent_pause <= next_sent_pause;
         pend_valid <= next_pend_valid;
         pend_pause <= next_pend_pause;
         rts_hold <= next_rts_hold;
         int_status <= next_int_status;
         state <= next_state;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_load <= 1'b0;
         tx_load_data <= 8'h00;
         tx_data_take <= 1'b0;
         rts_n <= 1'b1;
         irq <= 1'b0;
      end else begin
         tx_load <= pend_go || data_go;
         tx_load_data <= pend_go ? fc_char : data_go ? tx_data : tx_load_data;
         tx_data_take <= data_go;
         rts_n <= !rts_request || next_rts_hold;
         irq <= |(int_status & int_mask);
      end
   end

   property p_pause;
      @(posedge clock) disable iff (!resetn) pause_hit |=> tx_paused;
   endproperty
   a_pause: assert property (p_pause) else $error("pause not taken");

   property p_resume;
      @(posedge clock) disable iff (!resetn) tx_paused && resume_hit && !pause_hit |=> !tx_paused;
   endproperty
   a_resume: assert property (p_resume) else $error("resume not taken");

   property p_mode01;
      @(posedge clock) disable iff (!resetn)
         rx_char_valid && enh && enhanced_function_control[1:0] == 2'b01 && rx_char == pause_char_two |=> tx_paused;
   endproperty
   a_mode01: assert property (p_mode01) else $error("set two pause missed");

   property p_mode11;
      @(posedge clock) disable iff (!resetn)
         rx_char_valid && enh && enhanced_function_control[3:0] == 4'b1011 && rx_char == pause_char_two
         |=> tx_paused;
   endproperty
   a_mode11: assert property (p_mode11) else $error("either pause not accepted");

   property p_insert;
      @(posedge clock) disable iff (!resetn) need_pause |=> pend_valid && pend_pause ##[1:40] tx_load;
   endproperty
   a_insert: assert property (p_insert) else $error("pause not queued");

   property p_txset;
      @(posedge clock) disable iff (!resetn)
         pend_go && pend_pause && tx_mode == 2'b01 |=> tx_load_data == $past(pause_char_two);
   endproperty
   a_txset: assert property (p_txset) else $error("wrong pause char sent");

   property p_legacy;
      @(posedge clock) disable iff (!resetn) !enh |=> !tx_paused && !rts_hold && !pend_valid;
   endproperty
   a_legacy: assert property (p_legacy) else $error("enhanced state outside enhanced mode");

   property p_special;
      @(posedge clock) disable iff (!resetn) spc_hit |=> int_status[`UFC_ST_SPC];
   endproperty
   a_special: assert property (p_special) else $error("special char not flagged");

   property p_rts_hi;
      @(posedge clock) disable iff (!resetn) auto_rts && receive_fifo_level >= fc_high |=> rts_n;
   endproperty
   a_rts_hi: assert property (p_rts_hi) else $error("rts not forced high");

   property p_rts_keep;
      @(posedge clock) disable iff (!resetn) auto_rts && rts_hold && !level_under |=> rts_n;
   endproperty
   a_rts_keep: assert property (p_rts_keep) else $error("rts released early");

   property p_cts;
      @(posedge clock) disable iff (!resetn) cts_block |=> !tx_data_take;
   endproperty
   a_cts: assert property (p_cts) else $error("data sent under cts hold");

   property p_boundary;
      @(posedge clock) disable iff (!resetn) tx_load |-> state == UFC_LOAD && $past(shifter_idle);
   endproperty
   a_boundary: assert property (p_boundary) else $error("load off boundary");

   property p_first;
      @(posedge clock) disable iff (!resetn) pend_valid && at_boundary |=> !tx_data_take;
   endproperty
   a_first: assert property (p_first) else $error("data ahead of flow char");

   c_pause_resume: cover property (@(posedge clock) disable iff (!resetn) tx_paused ##[1:200] !tx_paused);
   c_insert: cover property (@(posedge clock) disable iff (!resetn) pend_go ##2 tx_data_take);
   c_rts: cover property (@(posedge clock) disable iff (!resetn) rts_hold ##[1:200] !rts_hold);
   c_irq: cover property (@(posedge clock) disable iff (!resetn) irq);
endmodule // ufc_flow_ctl

/* tb/ufc_remote.sv */
/*
 Far side of the transmit path: a shifter that takes loaded characters and sends them to the remote device.
 Assumes the block's clock and reset; the bench reads the queue got.
*/
module ufc_remote (
   input wire logic clock,
   input wire logic resetn,
   input wire logic tx_load,
   input wire logic [7:0] tx_load_data,
   output logic shifter_idle
);
   timeunit 1ns;
   timeprecision 1ns;
   // shift time kept short, still longer than the load handshake
   localparam int SHIFT = 8;
   logic [7:0] got[$];
   int busy;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy <= 0;
         shifter_idle <= 1'b1;
      end else if (tx_load) begin
         got.push_back(tx_load_data);
         busy <= SHIFT;
         shifter_idle <= 1'b0;
      end else if (busy > 1) begin
         busy <= busy - 1;
      end else begin
         busy <= 0;
         shifter_idle <= 1'b1;
      end
   end
endmodule // ufc_remote

/* tb/tb_top.sv */
/*
 Self-checking bench of the flow control block.
 Assumes ufc_defs.svh and the remote shifter model ufc_remote.
*/
`include "ufc_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, rx_char_valid = 0;
   logic tx_data_valid = 0, rts_request = 0, cts_n = 0, pready, pslverr, tx_data_take;
   logic shifter_idle, tx_load, rts_n, irq, err;
   logic [7:0] paddr = 0, rx_char = 0, receive_fifo_level = 0, tx_data = 0, tx_load_data;
   logic [31:0] pwdata = 0, prdata, rd;
   int fail_count = 0, cmp_count = 0, cyc = 0;
   always #25 clock = ~clock;
   ufc_flow_ctl ufc_flow_ctl_i (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
      .receive_fifo_level(receive_fifo_level), .tx_data(tx_data), .tx_data_valid(tx_data_valid),
      .tx_data_take(tx_data_take), .shifter_idle(shifter_idle), .tx_load(tx_load),
      .tx_load_data(tx_load_data), .rts_request(rts_request), .rts_n(rts_n), .cts_n(cts_n), .irq(irq));
   ufc_remote ufc_remote_i (.clock(clock), .resetn(resetn), .tx_load(tx_load),
      .tx_load_data(tx_load_data), .shifter_idle(shifter_idle));
   task results();
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard, well above the whole sequence
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   always @(posedge clock) if (tx_data_take) tx_data_valid <= 1'b0;
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", n, e, g);
         fail_count++;
      end
   endtask
   task apb(input logic w, input logic [5:0] i, input logic [7:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [5:0] i, input logic [7:0] d);
      apb(1'b1, i, d);
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task lvl(input logic [7:0] v);
      @(posedge clock);
      receive_fifo_level <= v;
      tick(3);
   endtask
   task rx(input logic [7:0] c);
      @(posedge clock);
      rx_char <= c;
      rx_char_valid <= 1'b1;
      @(posedge clock);
      rx_char_valid <= 1'b0;
      tick(1);
   endtask
   task send(input logic [7:0] d);
      @(posedge clock);
      tx_data <= d;
      tx_data_valid <= 1'b1;
   endtask
   task paused(input string n, input logic e);
      apb(1'b0, `UFC_IDX_FLOW, 8'h00);
      chk(n, {31'h0, e}, {31'h0, rd[0]});
   endtask
   task expect_char(input string n, input logic [7:0] e);
      int k;
      k = 0;
      while (ufc_remote_i.got.size() == 0 && k < 100) begin
         @(posedge clock);
         k++;
      end
      chk(n, {24'h0, e}, ufc_remote_i.got.size() ? {24'h0, ufc_remote_i.got.pop_front()} : 32'hFFFFFFFF);
   endtask
   task t_reset();
      apb(1'b0, `UFC_IDX_EFC, 8'h00);
      chk("efc reset", {24'h0, `UFC_EFC_RST}, rd);
      chk("rts_n reset", 1, rts_n);
      apb(1'b0, 6'h3F, 8'h00);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
   endtask
   task t_rts();
      wr(`UFC_IDX_FCLO, 8'h04);
      wr(`UFC_IDX_FCHI, 8'h0A);
      apb(1'b0, `UFC_IDX_FCHI, 8'h00);
      chk("high level", 32'h0A, rd);
      rts_request <= 1'b1;
      wr(`UFC_IDX_EFC, 8'h40);
      lvl(8'h0C);
      chk("rts legacy", 0, rts_n);
      lvl(8'h09);
      wr(`UFC_IDX_EFC, 8'h50);
      chk("rts below high", 0, rts_n);
      lvl(8'h0A);
      chk("rts at high", 1, rts_n);
      lvl(8'h04);
      chk("rts at low", 1, rts_n);
      lvl(8'h03);
      chk("rts below low", 0, rts_n);
      lvl(8'h05);
   endtask
   task t_cts();
      wr(`UFC_IDX_EFC, 8'h90);
      cts_n <= 1'b1;
      tick(4);
      send(8'h41);
      tick(12);
      chk("cts held", 0, ufc_remote_i.got.size());
      cts_n <= 1'b0;
      expect_char("cts data", 8'h41);
   endtask
   task t_rx();
      logic [7:0] t[5][5];
      t = '{'{8'h31, 8'h14, 8'h12, 8'h13, 1}, '{8'h32, 8'h13, 8'h11, 8'h14, 1},
         '{8'h3B, 8'h14, 8'h11, 8'h20, 1}, '{8'h30, 8'h13, 8'h11, 8'h14, 0}, '{8'h02, 8'h13, 8'h11, 8'h14, 0}};
      wr(`UFC_IDX_RES1, 8'h11);
      wr(`UFC_IDX_RES2, 8'h12);
      wr(`UFC_IDX_PAU1, 8'h13);
      wr(`UFC_IDX_PAU2, 8'h14);
      for (int r = 0; r < 5; r++) begin
         wr(`UFC_IDX_EFC, t[r][0]);
         rx(t[r][3]);
         paused("other pause", 1'b0);
         rx(t[r][1]);
         paused("pause seen", t[r][4][0]);
         send(8'h5A);
         tick(12);
         chk("paused data", t[r][4][0] ? 0 : 1, ufc_remote_i.got.size());
         rx(t[r][2]);
         expect_char("resumed data", 8'h5A);
         paused("resumed", 1'b0);
      end
   endtask
   task t_irq();
      wr(`UFC_IDX_MASK, 8'h01);
      wr(`UFC_IDX_EFC, 8'h10);
      wr(`UFC_IDX_STAT, 8'h07);
      rx(8'h13);
      chk("irq off", 0, irq);
      wr(`UFC_IDX_EFC, 8'h30);
      rx(8'h14);
      tick(1);
      chk("irq on", 1, irq);
      apb(1'b0, `UFC_IDX_STAT, 8'h00);
      chk("status special", 32'h01, rd);
      wr(`UFC_IDX_STAT, 8'h01);
      tick(2);
      chk("irq cleared", 0, irq);
      apb(1'b0, `UFC_IDX_STAT, 8'h00);
      chk("status cleared", 0, rd);
   endtask
   task t_ins();
      logic [7:0] t[2][3];
      t = '{'{8'hB4, 8'h14, 8'h12}, '{8'hB8, 8'h13, 8'h11}};
      for (int r = 0; r < 2; r++) begin
         wr(`UFC_IDX_EFC, t[r][0]);
         cts_n <= 1'b1;
         tick(4);
         send(8'h66);
         lvl(8'h0B);
         expect_char("pause sent", t[r][1]);
         lvl(8'h03);
         expect_char("resume sent", t[r][2]);
         cts_n <= 1'b0;
         expect_char("data after flow", 8'h66);
         lvl(8'h05);
      end
   endtask
   initial begin
      tick(16);
      resetn <= 1'b1;
      t_reset();
      t_rts();
      t_cts();
      t_rx();
      t_irq();
      t_ins();
      results();
   end
endmodule // tb_top
